// ### rtl/parm_pkg.sv
// constants, modes and field layouts of the position analogue ramp mapper
// assumes one 100 MHz clock domain shared by all users of this package
package parm_pkg;

    localparam int POS_W = 26;
    localparam int LEN_W = 27;
    localparam int CODE_W = 16;
    localparam int ACC_W = 28;
    localparam int SH_W = POS_W + CODE_W;

    localparam int CNT_PER_REV = 4096;
    localparam int REV_MAX = 16384;
    localparam logic [LEN_W-1:0] LEN_MAX = LEN_W'(CNT_PER_REV * REV_MAX);
    localparam logic [LEN_W-1:0] LEN_MIN = 27'h0000001;
    localparam logic [LEN_W-1:0] LEN_RST = LEN_MAX;

    localparam logic [CODE_W-1:0] CODE_MIN = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_MAX = 16'hFFFF;

    localparam logic [5:0] MOD_ITER = 6'h1A;
    localparam logic [5:0] DIV_ITER = 6'h2A;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_LEN = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_POS = 8'h14;
    localparam logic [7:0] ADDR_CODE = 8'h18;
    localparam logic [7:0] ADDR_ORG = 8'h1C;
    localparam logic [7:0] ADDR_SPAN = 8'h20;

    localparam int CMD_ORG_BIT = 0;
    localparam int CMD_END_BIT = 1;
    localparam int STAT_W = 7;
    localparam logic [STAT_W-1:0] STAT_RST = 7'h00;
    localparam logic [STAT_W-1:0] MASK_RST = 7'h00;

    typedef enum logic [1:0] {
        MODE_TEACH_SINGLE = 2'b00,
        MODE_TEACH_CYCLIC = 2'b01,
        MODE_PROG_SINGLE = 2'b10,
        MODE_PROG_CYCLIC = 2'b11
    } parm_mode_t;

    localparam parm_mode_t MODE_RST = MODE_TEACH_SINGLE;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MOD = 2'b01,
        ST_DIV = 2'b10,
        ST_LOAD = 2'b11
    } parm_state_t;

    typedef struct packed {
        logic cmd_rej;
        logic len_alarm;
        logic err_invalid;
        logic err_res;
        logic err_stroke;
        logic teach_done;
        logic origin_set;
    } parm_evt_t;

    typedef struct packed {
        logic [POS_W-1:0] origin;
        logic [LEN_W-1:0] len;
        logic rev;
    } parm_travel_t;

endpackage : parm_pkg

// ### rtl/parm_top.sv
// position to analogue code mapper with teach-in and programmed ramp modes
// assumes position comes from on-chip logic on mclk and moves < 2^25 per cycle
// Function
// - teach cyclic ramps origin-to-end, then repeats
// - cyclic modes enter neighbouring ramp beyond ends
// - origin command captures position, teach modes only
// - end command captures position, teach modes only
// - end equal origin gives minimum-stroke error
// - travel beyond count range gives resolution error
// - reversing back over origin gives invalid error
// - programmed single ramp spans the length register
// - single ramp clamps min before, max after
// - length accepts 1..67108864, resets to 67108864
// - length writable only in programmed modes
// - position is 26 bits, 67108864 counts
// - output code 16 bits, 65536 levels
// - programmed cyclic repeats ramp every length counts
// - relative 0 maps min, N-1 maps max
// - exactly one of four modes active
// - length above maximum raises alarm in programmed modes
`timescale 1ns/100ps
module parm_top
    import parm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [POS_W-1:0] position,
    output logic [CODE_W-1:0] dac_code,
    output logic dac_update,
    output logic irq
);

    parm_mode_t mode;
    logic [LEN_W-1:0] len;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    parm_evt_t ev;
    parm_travel_t travel;

    logic armed;
    logic dir_set;
    logic dir_neg;
    logic signed [ACC_W-1:0] rel_acc;
    logic [POS_W-1:0] org_cap;
    logic [POS_W-1:0] pos_prev;

    parm_state_t state;
    logic [5:0] cnt;
    logic [SH_W-1:0] sh;
    logic [LEN_W-1:0] rem;
    logic [LEN_W-1:0] n_cur;
    logic [LEN_W-1:0] den;
    logic [CODE_W-1:0] quo;
    logic clamp_hi;

    // bus decode
    logic acc_done;
    logic wr;
    logic wr_ctrl;
    logic wr_cmd;
    logic wr_len;
    logic wr_stat;
    logic wr_mask;
    logic addr_hit;
    logic [31:0] rd_mux;

    assign acc_done = psel & penable & pready;
    assign wr = acc_done & pwrite;
    assign wr_ctrl = wr && (paddr == ADDR_CTRL);
    assign wr_cmd = wr && (paddr == ADDR_CMD);
    assign wr_len = wr && (paddr == ADDR_LEN);
    assign wr_stat = wr && (paddr == ADDR_STAT);
    assign wr_mask = wr && (paddr == ADDR_MASK);

    logic is_teach;
    logic is_prog;
    logic is_cyclic;
    logic cmd_org;
    logic cmd_end;

    assign is_teach = ~mode[1];
    assign is_prog = mode[1];
    assign is_cyclic = mode[0];
    assign cmd_org = wr_cmd & pwdata[CMD_ORG_BIT];
    // both bits in one write: origin wins, end is dropped
    assign cmd_end = wr_cmd & pwdata[CMD_END_BIT] & ~pwdata[CMD_ORG_BIT];

    // teach bookkeeping
    logic signed [POS_W-1:0] step;
    logic signed [ACC_W-1:0] step_ext;
    logic [ACC_W-1:0] mag;
    logic reversal;

    assign step = signed'(position - pos_prev);
    assign step_ext = ACC_W'(step);
    assign mag = rel_acc[ACC_W-1] ? ACC_W'(-rel_acc) : ACC_W'(rel_acc);
    // strictly beyond the origin; sitting on it again is still legal
    assign reversal = armed & dir_set & (rel_acc != '0) & (rel_acc[ACC_W-1] != dir_neg);

    always_comb begin
        ev = '0;
        ev.origin_set = cmd_org & is_teach;
        ev.err_invalid = reversal;
        ev.err_stroke = cmd_end & is_teach & armed & ~reversal & (rel_acc == '0);
        ev.err_res = cmd_end & is_teach & armed & ~reversal & (rel_acc != '0)
            & (mag >= ACC_W'(LEN_MAX));
        ev.teach_done = cmd_end & is_teach & armed & ~reversal & (rel_acc != '0)
            & (mag < ACC_W'(LEN_MAX));
        ev.cmd_rej = ((cmd_org | cmd_end) & ~is_teach) | (cmd_end & is_teach & ~armed)
            | (wr_len & (~is_prog | (pwdata == 32'h00000000)));
        ev.len_alarm = wr_len & is_prog & (pwdata > 32'(LEN_MAX));
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode <= MODE_RST;
        end else if (wr_ctrl) begin
            mode <= parm_mode_t'(pwdata[1:0]);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            len <= LEN_RST;
        end else if (wr_len && is_prog && pwdata >= 32'(LEN_MIN) && pwdata <= 32'(LEN_MAX)) begin
            len <= pwdata[LEN_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pos_prev <= '0;
            org_cap <= '0;
            rel_acc <= '0;
            armed <= 1'b0;
            dir_set <= 1'b0;
            dir_neg <= 1'b0;
            travel <= '{origin: '0, len: LEN_RST, rev: 1'b0};
        end else begin
            pos_prev <= position;
            if (wr_ctrl) begin
                // any mode write abandons a teach in progress
                armed <= 1'b0;
            end else if (ev.origin_set) begin
                org_cap <= position;
                rel_acc <= '0;
                dir_set <= 1'b0;
                armed <= 1'b1;
            end else if (armed) begin
                rel_acc <= rel_acc + step_ext;
                if (!dir_set && rel_acc != '0) begin
                    dir_set <= 1'b1;
                    dir_neg <= rel_acc[ACC_W-1];
                end
                if (reversal || cmd_end) begin
                    armed <= 1'b0;
                end
                if (ev.teach_done) begin
                    travel <= '{origin: org_cap, len: mag[LEN_W-1:0] + LEN_MIN,
                        rev: rel_acc[ACC_W-1]};
                end
            end
        end
    end

    // status, mask, interrupt
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status <= STAT_RST;
        end else begin
            // a new event wins over a clear in the same cycle
            status <= (status & ~(wr_stat ? pwdata[STAT_W-1:0] : STAT_RST)) | ev;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mask <= MASK_RST;
        end else if (wr_mask) begin
            mask <= pwdata[STAT_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // mapping arithmetic
    logic [POS_W-1:0] eff_org;
    logic [LEN_W-1:0] eff_len;
    logic eff_rev;
    logic [POS_W-1:0] rel_pos;
    logic [LEN_W-1:0] beyond;
    logic [LEN_W-1:0] gap_half;
    logic [LEN_W-1:0] r_single;
    logic single_hi;
    logic [LEN_W-1:0] trial;
    logic [LEN_W-1:0] divisor;
    logic ge;
    logic [LEN_W-1:0] rem_step;
    logic [SH_W-1:0] mul;

    assign eff_org = is_teach ? travel.origin : '0;
    assign eff_len = is_teach ? travel.len : len;
    assign eff_rev = is_teach & travel.rev;
    assign rel_pos = eff_rev ? (eff_org - position) : (position - eff_org);
    assign beyond = {1'b0, rel_pos} - eff_len;
    // the positions outside the travel are split evenly, half before, half after
    assign gap_half = (LEN_MAX - eff_len) >> 1;
    assign single_hi = ({1'b0, rel_pos} >= eff_len) && (beyond < gap_half);

    always_comb begin
        if ({1'b0, rel_pos} < eff_len) begin
            r_single = {1'b0, rel_pos};
        end else if (single_hi) begin
            r_single = eff_len - LEN_MIN;
        end else begin
            r_single = '0;
        end
    end

    assign trial = {rem[LEN_W-2:0], sh[SH_W-1]};
    assign divisor = (state == ST_MOD) ? n_cur : den;
    assign ge = trial >= divisor;
    assign rem_step = ge ? (trial - divisor) : trial;
    // r * 65535 without a multiplier
    assign mul = {rem[POS_W-1:0], 16'h0000} - {16'h0000, rem[POS_W-1:0]};

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt <= '0;
            sh <= '0;
            rem <= '0;
            n_cur <= LEN_RST;
            den <= '0;
            quo <= '0;
            clamp_hi <= 1'b0;
            dac_code <= CODE_MIN;
            dac_update <= 1'b0;
        end else begin
            dac_update <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    n_cur <= eff_len;
                    clamp_hi <= ~is_cyclic & single_hi;
                    if (is_cyclic) begin
                        sh <= {rel_pos, 16'h0000};
                        rem <= '0;
                        cnt <= MOD_ITER;
                        state <= ST_MOD;
                    end else begin
                        rem <= r_single;
                        state <= ST_LOAD;
                    end
                end
                ST_MOD: begin
                    rem <= rem_step;
                    sh <= sh << 1;
                    cnt <= cnt - 6'h01;
                    if (cnt == 6'h01) begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    sh <= mul;
                    rem <= '0;
                    den <= n_cur - LEN_MIN;
                    cnt <= DIV_ITER;
                    state <= ST_DIV;
                end
                ST_DIV: begin
                    rem <= rem_step;
                    sh <= sh << 1;
                    quo <= {quo[CODE_W-2:0], ge};
                    cnt <= cnt - 6'h01;
                    if (cnt == 6'h01) begin
                        // a one-count travel sits at its own last position
                        dac_code <= (den == '0) ? CODE_MAX : {quo[CODE_W-2:0], ge};
                        dac_update <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // register read and APB answer, one wait state
    always_comb begin
        addr_hit = 1'b1;
        rd_mux = 32'h00000000;
        unique case (paddr)
            ADDR_CTRL: rd_mux = {30'h00000000, mode};
            ADDR_CMD: rd_mux = {31'h00000000, armed};
            ADDR_LEN: rd_mux = {5'h00, len};
            ADDR_STAT: rd_mux = {25'h0000000, status};
            ADDR_MASK: rd_mux = {25'h0000000, mask};
            ADDR_POS: rd_mux = {6'h00, position};
            ADDR_CODE: rd_mux = {16'h0000, dac_code};
            ADDR_ORG: rd_mux = {6'h00, travel.origin};
            ADDR_SPAN: rd_mux = {travel.rev, 4'h0, travel.len};
            default: addr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= ~addr_hit;
            end else begin
                prdata <= 32'h00000000;
                pslverr <= 1'b0;
            end
        end
    end

    // checks
    sequence seq_start;
        state == ST_IDLE;
    endsequence

    sequence seq_done;
        dac_update;
    endsequence

    chk_map_bound: assert property (@(posedge mclk) disable iff (!rst_n)
        seq_start |-> ##[1:80] seq_done)
        else $error("mapping did not finish in time");

    chk_origin_take: assert property (@(posedge mclk) disable iff (!rst_n)
        (cmd_org && is_teach && !wr_ctrl) |=> (armed && org_cap == $past(position)
            && status[0]))
        else $error("origin capture not taken");

    chk_cmd_reject: assert property (@(posedge mclk) disable iff (!rst_n)
        ((cmd_org || cmd_end) && is_prog) |=> (status[6] && $stable(travel)))
        else $error("teach command in programmed mode not refused");

    chk_min_stroke: assert property (@(posedge mclk) disable iff (!rst_n)
        (cmd_end && is_teach && armed && rel_acc == '0) |=> (status[2] && !armed
            && $stable(travel)))
        else $error("zero travel not refused");

    chk_reverse_err: assert property (@(posedge mclk) disable iff (!rst_n)
        (armed && dir_set && !wr_ctrl && !cmd_org && rel_acc != '0
            && rel_acc[ACC_W-1] != dir_neg)
            |=> (status[4] && !armed))
        else $error("reversal over origin not flagged");

    chk_len_reset: assert property (@(posedge mclk)
        !rst_n |=> (len == LEN_MAX && mode == MODE_TEACH_SINGLE))
        else $error("length or mode wrong after reset");

    chk_len_alarm: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_len && is_prog && pwdata > 32'h04000000) |=> (status[5] && $stable(len)))
        else $error("oversize length not alarmed");

    chk_len_locked: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_len && is_teach) |=> ($stable(len) && status[6]))
        else $error("length changed outside programmed mode");

    chk_clamp_high: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == ST_DIV && cnt == 6'h01 && clamp_hi) |=> (dac_code == CODE_MAX))
        else $error("single ramp did not clamp high");

    chk_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 (irq == |$past(status & mask)))
        else $error("interrupt level does not follow masked status");

endmodule : parm_top

// ### tb/parm_pos_model.sv
// far side model: position source and output converter stage
// assumes tb sets target off-edge; teach moves kept below 2^25 per cycle
`timescale 1ns/100ps
module parm_pos_model
    import parm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [POS_W-1:0] target,
    output logic [POS_W-1:0] position,
    input wire logic [CODE_W-1:0] dac_code,
    input wire logic dac_update,
    output logic [CODE_W-1:0] last_code
);
    // absolute count, wraps at 67108864
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            position <= '0;
        end else begin
            position <= target;
        end
    end
    // converter only latches on the refresh pulse
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last_code <= CODE_MIN;
        end else if (dac_update) begin
            last_code <= dac_code;
        end
    end
endmodule : parm_pos_model

// ### tb/parm_top_tb_top.sv
// self-checking bench for the ramp mapper, apb master plus position model
// assumes one 100 MHz clock and the block's apb register map
`timescale 1ns/100ps
module parm_top_tb_top
    import parm_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [POS_W-1:0] target = '0;
    logic [POS_W-1:0] position;
    logic [CODE_W-1:0] dac_code;
    logic dac_update;
    logic irq;
    logic [CODE_W-1:0] last_code;
    logic last_err;
    int mismatches = 0;
    int checked = 0;

    always #5 mclk = ~mclk;

    parm_top i_dut (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .position(position),
        .dac_code(dac_code), .dac_update(dac_update), .irq(irq));

    parm_pos_model i_pos (.mclk(mclk), .rst_n(rst_n), .target(target),
        .position(position), .dac_code(dac_code), .dac_update(dac_update),
        .last_code(last_code));

    task final_report;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // request held until pready seen high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            final_report();
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h00000000, r);
        chk(r, exp);
    endtask : rd

    // second pulse guarantees the sample was taken after the move
    task code_is(input logic [POS_W-1:0] p, input logic [CODE_W-1:0] exp);
        int n;
        int k;
        target <= p;
        for (k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (dac_update !== 1'b1 && n < 200);
            if (n >= 200) begin
                mismatches++;
                final_report();
            end
        end
        @(posedge mclk);
        chk({16'h0000, last_code}, {16'h0000, exp});
    endtask : code_is

    task move(input logic [POS_W-1:0] p);
        target <= p;
        repeat (3) @(posedge mclk);
    endtask : move

    task t_reset_map;
        rd(ADDR_LEN, 32'h04000000);
        rd(ADDR_CTRL, 32'h00000000);
        rd(ADDR_STAT, 32'h00000000);
        rd(8'h24, 32'h00000000);
        chk(last_err, 1'b1);
        $display("test reset_map done");
    endtask : t_reset_map

    task t_prog_single;
        wr(ADDR_CTRL, 32'h00000002);
        wr(ADDR_LEN, 32'h00001000);
        rd(ADDR_LEN, 32'h00001000);
        code_is(26'h0000000, 16'h0000);
        code_is(26'h0000FFF, 16'hFFFF);
        code_is(26'h0000800, 16'h8007);
        code_is(26'h0001388, 16'hFFFF);
        code_is(26'h3FFFFFF, 16'h0000);
        wr(ADDR_LEN, 32'h00000001);
        code_is(26'h0000000, 16'hFFFF);
        $display("test prog_single done");
    endtask : t_prog_single

    task t_prog_cyclic;
        wr(ADDR_CTRL, 32'h00000003);
        wr(ADDR_LEN, 32'h00001000);
        code_is(26'h0001000, 16'h0000);
        code_is(26'h0001FFF, 16'hFFFF);
        code_is(26'h3FFFFFF, 16'hFFFF);
        wr(ADDR_CMD, 32'h00000001);
        rd(ADDR_STAT, 32'h00000040);
        $display("test prog_cyclic done");
    endtask : t_prog_cyclic

    task t_len_irq;
        wr(ADDR_STAT, 32'h0000007F);
        wr(ADDR_MASK, 32'h00000020);
        wr(ADDR_LEN, 32'h04000001);
        rd(ADDR_STAT, 32'h00000020);
        rd(ADDR_LEN, 32'h00001000);
        chk(irq, 1'b1);
        wr(ADDR_STAT, 32'h00000020);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        wr(ADDR_LEN, 32'h00000000);
        wr(ADDR_CTRL, 32'h00000001);
        wr(ADDR_LEN, 32'h00000800);
        rd(ADDR_STAT, 32'h00000040);
        rd(ADDR_CTRL, 32'h00000001);
        $display("test len_irq done");
    endtask : t_len_irq

    task t_teach_cyclic;
        wr(ADDR_STAT, 32'h0000007F);
        move(26'h00003E8);
        wr(ADDR_CMD, 32'h00000001);
        move(26'h00013E7);
        wr(ADDR_CMD, 32'h00000002);
        rd(ADDR_STAT, 32'h00000003);
        rd(ADDR_ORG, 32'h000003E8);
        rd(ADDR_SPAN, 32'h00001000);
        code_is(26'h00003E8, 16'h0000);
        code_is(26'h00013E7, 16'hFFFF);
        code_is(26'h00013E8, 16'h0000);
        code_is(26'h00003E7, 16'hFFFF);
        $display("test teach_cyclic done");
    endtask : t_teach_cyclic

    task t_teach_errors;
        int k;
        wr(ADDR_CTRL, 32'h00000000);
        wr(ADDR_STAT, 32'h0000007F);
        move(26'h00000C8);
        wr(ADDR_CMD, 32'h00000001);
        wr(ADDR_CMD, 32'h00000002);
        rd(ADDR_STAT, 32'h00000005);
        wr(ADDR_CTRL, 32'h00000001);
        wr(ADDR_STAT, 32'h0000007F);
        move(26'h00003E8);
        wr(ADDR_CMD, 32'h00000001);
        move(26'h000044C);
        move(26'h0000384);
        rd(ADDR_STAT, 32'h00000011);
        wr(ADDR_CMD, 32'h00000002);
        rd(ADDR_STAT, 32'h00000051);
        wr(ADDR_STAT, 32'h0000007F);
        move(26'h0000000);
        wr(ADDR_CMD, 32'h00000001);
        for (k = 1; k <= 4; k++) begin
            move(26'(k * 32'h01000000));
        end
        wr(ADDR_CMD, 32'h00000002);
        rd(ADDR_STAT, 32'h00000009);
        $display("test teach_errors done");
    endtask : t_teach_errors

    // travel taught downwards, so the ramp runs against the count direction
    task t_teach_single;
        wr(ADDR_CTRL, 32'h00000000);
        wr(ADDR_STAT, 32'h0000007F);
        move(26'h0002000);
        wr(ADDR_CMD, 32'h00000001);
        rd(ADDR_CMD, 32'h00000001);
        move(26'h0001001);
        wr(ADDR_CMD, 32'h00000002);
        rd(ADDR_STAT, 32'h00000003);
        rd(ADDR_SPAN, 32'h80001000);
        code_is(26'h0002000, 16'h0000);
        code_is(26'h0001001, 16'hFFFF);
        code_is(26'h0002001, 16'h0000);
        code_is(26'h0001000, 16'hFFFF);
        rd(ADDR_CODE, 32'h0000FFFF);
        $display("test teach_single done");
    endtask : t_teach_single

    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_map();
        t_prog_single();
        t_prog_cyclic();
        t_len_irq();
        t_teach_cyclic();
        t_teach_errors();
        t_teach_single();
        final_report();
    end
endmodule : parm_top_tb_top
